/* File: bzc_control.v */
// bias and zero check control with AHB-Lite register slave
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`include "bzc_defs.vh"
// Summary of operation
// - bias off command disables bias output, bias on command enables it
// - clears and restore-defaults keep the last bias state; factory reset is off
// - bus command and front-panel key share one bias enable flag
// - bias reaches the input only when enabled and zero check off
// - bias value is clamped to plus or minus five volts in 2.5 mV steps
// - zero check command: 0 off, 1 on, 2 start correction
// - clears and restore-defaults load the programmed default zero check state
// - zero check forces suppression, bias and x10 gain off
// - releasing zero check brings back the retained settings
// - correction forces zero check on, runs, then restores previous state
// - oversized offset flags error, shows message, raises masked service request
// - correction constants stay volatile until save-setup copies them
// - signal output is enabled only while zero check is off
// - commands are buffered and acted upon at the execute character
// - bias value and state, then zero check, then correction
module bzc_control #(
	parameter CORR_CYCLES = `BZC_CORR_CYCLES,
	parameter [15:0] OFFSET_LIMIT = `BZC_OFFSET_LIMIT
) (
	input wire clk,
	input wire reset_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire dev_clear_pin,
	input wire bias_key_pin,
	input wire [15:0] measured_offset,
	output wire bias_drive,
	output reg [11:0] bias_level,
	output wire supp_enable,
	output wire x10_enable,
	output wire signal_out_enable,
	output wire zero_check,
	output reg correction_error_message,
	output wire srq,
	output reg [15:0] nv_corr_const,
	output reg nv_save_strobe
);
	////////////////////////////////////////////////////////////////////////////////
	// reset and pin synchronisers
	reg rst_meta;
	reg rst_n;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	reg clr_meta;
	reg clr_sync;
	reg clr_last;
	reg key_meta;
	reg key_sync;
	reg key_last;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clr_meta <= 1'b0;
			clr_sync <= 1'b0;
			clr_last <= 1'b0;
			key_meta <= 1'b0;
			key_sync <= 1'b0;
			key_last <= 1'b0;
		end else begin
			clr_meta <= dev_clear_pin;
			clr_sync <= clr_meta;
			clr_last <= clr_sync;
			key_meta <= bias_key_pin;
			key_sync <= key_meta;
			key_last <= key_sync;
		end
	end
	wire clr_event;
	wire key_event;
	assign clr_event = clr_sync & ~clr_last;
	assign key_event = key_sync & ~key_last;

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states
	reg wr_pend;
	reg [7:0] wr_addr;
	wire addr_phase;
	assign addr_phase = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (hready) begin
			wr_pend <= addr_phase & hwrite;
			wr_addr <= haddr[7:0];
		end
	end
	wire wr_char;
	wire wr_value;
	wire wr_ctrl;
	wire wr_status;
	assign wr_char = wr_pend && wr_addr == `BZC_ADDR_CHAR;
	assign wr_value = wr_pend && wr_addr == `BZC_ADDR_VALUE;
	assign wr_ctrl = wr_pend && wr_addr == `BZC_ADDR_CTRL;
	assign wr_status = wr_pend && wr_addr == `BZC_ADDR_STATUS;

	////////////////////////////////////////////////////////////////////////////////
	// command parser and correction sequencer
	wire exec;
	wire p_bias;
	wire p_bias_on;
	wire p_zc;
	wire p_zc_on;
	wire p_corr;
	wire p_restore;
	wire p_save;
	bzc_parser u_parser (
		.clk(clk),
		.rst_n(rst_n),
		.char_valid(wr_char),
		.char_data(hwdata[7:0]),
		.exec(exec),
		.bias_pend(p_bias),
		.bias_on(p_bias_on),
		.zc_pend(p_zc),
		.zc_on(p_zc_on),
		.corr_pend(p_corr),
		.restore_pend(p_restore),
		.save_pend(p_save)
	);

	reg corr_start;
	wire corr_busy;
	wire corr_done;
	wire corr_fail;
	wire [15:0] corr_const;
	bzc_correct #(
		.CORR_CYCLES(CORR_CYCLES),
		.OFFSET_LIMIT(OFFSET_LIMIT)
	) u_correct (
		.clk(clk),
		.rst_n(rst_n),
		.start(corr_start),
		.offset(measured_offset),
		.busy(corr_busy),
		.done(corr_done),
		.error(corr_fail),
		.corr_const(corr_const)
	);

	////////////////////////////////////////////////////////////////////////////////
	// bias value staging
	// saturate instead of wrapping so an oversized value keeps its polarity
	function [11:0] clamp_bias;
		input [31:0] v;
		reg [31:0] lim;
		begin
			lim = `BZC_BIAS_MAX;
			if ($signed(v) > $signed(lim))
				clamp_bias = lim[11:0];
			else if ($signed(v) < -$signed(lim))
				clamp_bias = 12'h000 - lim[11:0];
			else
				clamp_bias = v[11:0];
		end
	endfunction

	reg [11:0] value_stage;
	reg value_pend;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value_stage <= 12'h000;
			value_pend <= 1'b0;
			bias_level <= 12'h000;
		end else begin
			if (exec && value_pend && !p_restore)
				bias_level <= value_stage;
			if (wr_value) begin
				value_stage <= clamp_bias(hwdata);
				value_pend <= 1'b1;
			end else if (exec) begin
				value_pend <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control settings
	localparam [3:0] CTRL_RESET = `BZC_CTRL_RESET;
	reg supp_setting;
	reg x10_setting;
	reg default_zc;
	reg srq_mask;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			supp_setting <= CTRL_RESET[`BZC_CTRL_SUPP];
			x10_setting <= CTRL_RESET[`BZC_CTRL_X10];
			default_zc <= CTRL_RESET[`BZC_CTRL_DEFZC];
			srq_mask <= CTRL_RESET[`BZC_CTRL_SRQMASK];
		end else if (wr_ctrl) begin
			supp_setting <= hwdata[`BZC_CTRL_SUPP];
			x10_setting <= hwdata[`BZC_CTRL_X10];
			default_zc <= hwdata[`BZC_CTRL_DEFZC];
			srq_mask <= hwdata[`BZC_CTRL_SRQMASK];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bias enable and zero check state
	reg bias_en;
	reg zc_state;
	reg corr_pending_start;
	reg next_bias_en;
	reg next_zc;
	always @* begin
		next_bias_en = bias_en;
		next_zc = zc_state;
		if (key_event)
			next_bias_en = ~bias_en;
		if (exec) begin
			// bias command
			// restore in the same string overrides it
			if (p_bias && !p_restore)
				next_bias_en = p_bias_on;
			if (p_zc)
				next_zc = p_zc_on;
		end
		// bias keeps last state; default zero check
		if (clr_event || (exec && p_restore))
			next_zc = default_zc;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bias_en <= 1'b0;
			zc_state <= 1'b1;
			corr_start <= 1'b0;
			corr_pending_start <= 1'b0;
		end else begin
			bias_en <= next_bias_en;
			zc_state <= next_zc;
			corr_start <= exec && p_corr && !p_restore && !corr_busy;
			corr_pending_start <= corr_start;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// forced outputs; settings are retained so release restores them
	wire zc_active;
	// correction holds zero check on, stored state untouched
	assign zc_active = zc_state | corr_busy | corr_pending_start | corr_start;
	assign zero_check = zc_active;
	// forced off while checking; retained settings return
	assign supp_enable = supp_setting & ~zc_active;
	assign x10_enable = x10_setting & ~zc_active;
	// bias only with zero check off
	assign bias_drive = bias_en & ~zc_active;
	assign signal_out_enable = ~zc_active;

	////////////////////////////////////////////////////////////////////////////////
	// correction error and nonvolatile save
	reg save_req;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			correction_error_message <= 1'b0;
			nv_corr_const <= 16'h0000;
			nv_save_strobe <= 1'b0;
			save_req <= 1'b0;
		end else begin
			// sticky error, set wins over clear
			if (corr_fail)
				correction_error_message <= 1'b1;
			else if ((wr_status && hwdata[`BZC_ST_ERR]) || clr_event)
				correction_error_message <= 1'b0;
			nv_save_strobe <= 1'b0;
			if (save_req && !corr_busy && !corr_start && !corr_pending_start) begin
				save_req <= 1'b0;
				nv_corr_const <= corr_const;
				nv_save_strobe <= 1'b1;
			end
			// save waits for any correction started by the same string; a new request wins
			if (exec && p_save && !p_restore)
				save_req <= 1'b1;
		end
	end
	assign srq = correction_error_message & srq_mask;

	////////////////////////////////////////////////////////////////////////////////
	// read data, captured in the address phase
	wire [31:0] status_word;
	assign status_word = {23'h000000, value_pend, correction_error_message, corr_busy,
		signal_out_enable, x10_enable, supp_enable, bias_drive, zc_active, bias_en};
	reg [31:0] next_rdata;
	always @* begin
		next_rdata = 32'h00000000;
		case (haddr[7:0])
		`BZC_ADDR_VALUE:
			next_rdata = {{20{bias_level[11]}}, bias_level};
		`BZC_ADDR_CTRL:
			next_rdata = {28'h0000000, srq_mask, default_zc, x10_setting, supp_setting};
		`BZC_ADDR_STATUS:
			next_rdata = status_word;
		`BZC_ADDR_CONST:
			next_rdata = {16'h0000, corr_const};
		`BZC_ADDR_NVCONST:
			next_rdata = {16'h0000, nv_corr_const};
		default:
			next_rdata = 32'h00000000;
		endcase
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hrdata <= 32'h00000000;
		else if (addr_phase && !hwrite)
			hrdata <= next_rdata;
	end

	// corr_done is observed through the busy flag falling
	wire unused_done;
	assign unused_done = corr_done | (|hsize);
endmodule

/* File: bzc_defs.vh */
// register map, fields, command codes and timing for the bias and zero check control
`ifndef BZC_DEFS_VH
`define BZC_DEFS_VH
`define BZC_ADDR_CHAR 8'h00
`define BZC_ADDR_VALUE 8'h04
`define BZC_ADDR_CTRL 8'h08
`define BZC_ADDR_STATUS 8'h0C
`define BZC_ADDR_CONST 8'h10
`define BZC_ADDR_NVCONST 8'h14
`define BZC_CTRL_SUPP 0
`define BZC_CTRL_X10 1
`define BZC_CTRL_DEFZC 2
`define BZC_CTRL_SRQMASK 3
`define BZC_CTRL_RESET 4'h4
`define BZC_ST_BIAS 0
`define BZC_ST_ZC 1
`define BZC_ST_BIASOUT 2
`define BZC_ST_SUPP 3
`define BZC_ST_X10 4
`define BZC_ST_OUT 5
`define BZC_ST_BUSY 6
`define BZC_ST_ERR 7
`define BZC_ST_VPEND 8
`define BZC_CH_B 8'h42
`define BZC_CH_C 8'h43
`define BZC_CH_L 8'h4C
`define BZC_CH_X 8'h58
`define BZC_CH_0 8'h30
`define BZC_CH_1 8'h31
`define BZC_CH_2 8'h32
`define BZC_BIAS_RANGE_MV 5000
`define BZC_BIAS_STEP_UV 2500
`define BZC_BIAS_MAX ((`BZC_BIAS_RANGE_MV * 1000) / `BZC_BIAS_STEP_UV)
`define BZC_CLK_PERIOD_NS 5
`define BZC_CORR_TIME_NS 1000
`define BZC_CORR_CYCLES ((`BZC_CORR_TIME_NS + `BZC_CLK_PERIOD_NS - 1) / `BZC_CLK_PERIOD_NS)
`define BZC_OFFSET_LIMIT 16'h1000
`endif

/* File: bzc_parser.v */
// command character parser holding pending commands until execute
`timescale 1ns/100ps
`include "bzc_defs.vh"
module bzc_parser (
	input wire clk,
	input wire rst_n,
	input wire char_valid,
	input wire [7:0] char_data,
	output reg exec,
	output reg bias_pend,
	output reg bias_on,
	output reg zc_pend,
	output reg zc_on,
	output reg corr_pend,
	output reg restore_pend,
	output reg save_pend
);
	localparam ST_IDLE = 2'd0;
	localparam ST_B = 2'd1;
	localparam ST_C = 2'd2;
	localparam ST_L = 2'd3;
	reg [1:0] state;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			exec <= 1'b0;
			bias_pend <= 1'b0;
			bias_on <= 1'b0;
			zc_pend <= 1'b0;
			zc_on <= 1'b0;
			corr_pend <= 1'b0;
			restore_pend <= 1'b0;
			save_pend <= 1'b0;
		end else begin
			exec <= 1'b0;
			// pending set is consumed on the cycle after execute
			if (exec) begin
				bias_pend <= 1'b0;
				zc_pend <= 1'b0;
				corr_pend <= 1'b0;
				restore_pend <= 1'b0;
				save_pend <= 1'b0;
			end
			if (char_valid) begin
				case (state)
				ST_B: begin
					state <= ST_IDLE;
					if (char_data == `BZC_CH_0 || char_data == `BZC_CH_1) begin
						bias_pend <= 1'b1;
						bias_on <= (char_data == `BZC_CH_1);
					end
				end
				ST_C: begin
					state <= ST_IDLE;
					if (char_data == `BZC_CH_0 || char_data == `BZC_CH_1) begin
						zc_pend <= 1'b1;
						zc_on <= (char_data == `BZC_CH_1);
					end else if (char_data == `BZC_CH_2) begin
						corr_pend <= 1'b1;
					end
				end
				ST_L: begin
					state <= ST_IDLE;
					if (char_data == `BZC_CH_1)
						save_pend <= 1'b1;
					else if (char_data == `BZC_CH_2)
						restore_pend <= 1'b1;
				end
				default: begin
					if (char_data == `BZC_CH_B)
						state <= ST_B;
					else if (char_data == `BZC_CH_C)
						state <= ST_C;
					else if (char_data == `BZC_CH_L)
						state <= ST_L;
					else if (char_data == `BZC_CH_X)
						exec <= 1'b1;
				end
				endcase
			end
		end
	end
endmodule

/* File: bzc_correct.v */
// zero correction sequencer with offset limit check
`timescale 1ns/100ps
`include "bzc_defs.vh"
module bzc_correct #(
	parameter CORR_CYCLES = `BZC_CORR_CYCLES,
	parameter [15:0] OFFSET_LIMIT = `BZC_OFFSET_LIMIT
) (
	input wire clk,
	input wire rst_n,
	input wire start,
	input wire [15:0] offset,
	output reg busy,
	output reg done,
	output reg error,
	output reg [15:0] corr_const
);
	reg [15:0] count;
	wire [15:0] mag;
	assign mag = offset[15] ? (~offset + 16'h0001) : offset;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			done <= 1'b0;
			error <= 1'b0;
			count <= 16'h0000;
			corr_const <= 16'h0000;
		end else begin
			done <= 1'b0;
			error <= 1'b0;
			if (!busy && start) begin
				busy <= 1'b1;
				count <= CORR_CYCLES[15:0];
			end else if (busy) begin
				if (count > 16'h0001) begin
					count <= count - 16'h0001;
				end else begin
					busy <= 1'b0;
					done <= 1'b1;
					if (mag > OFFSET_LIMIT)
						error <= 1'b1;
					else
						corr_const <= offset;
				end
			end
		end
	end
endmodule

/* File: bzc_control_props.sv */
// assertions on the ports of the bias and zero check control
`timescale 1ns/100ps
module bzc_control_props #(
	parameter CORR_CYCLES = 4,
	parameter [15:0] OFFSET_LIMIT = 16'h1000
) (
	input wire clk,
	input wire reset_n,
	input wire bias_key_pin,
	input wire dev_clear_pin,
	input wire bias_drive,
	input wire [11:0] bias_level,
	input wire supp_enable,
	input wire x10_enable,
	input wire signal_out_enable,
	input wire zero_check,
	input wire correction_error_message,
	input wire srq,
	input wire [15:0] nv_corr_const,
	input wire nv_save_strobe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////
	// key press seen while the input is unchecked
	sequence s_key_idle;
		!zero_check ##1 $rose(bias_key_pin);
	endsequence
	property p_key; s_key_idle |-> ##[2:8] $changed(bias_drive); endproperty
	property p_bias_gate; bias_drive |-> !zero_check; endproperty
	property p_supp_gate; supp_enable |-> !zero_check; endproperty
	property p_x10_gate; x10_enable |-> !zero_check; endproperty
	property p_out_gate; signal_out_enable == !zero_check; endproperty
	property p_reset_zc; $rose(reset_n) |-> zero_check; endproperty
	property p_nv_hold; !$stable(nv_corr_const) |-> nv_save_strobe || $past(nv_save_strobe);
	endproperty
	property p_srq; srq |-> correction_error_message; endproperty
	property p_clear_err; $rose(dev_clear_pin) |-> ##[1:8] !correction_error_message;
	endproperty
	property p_range; $signed(bias_level) <= 2000 && $signed(bias_level) >= -2000; endproperty
	////////////////////////////////////////////////////////////////
	a_key: assert property (p_key) else $error("key did not toggle bias");
	a_bias_gate: assert property (p_bias_gate) else $error("bias under zero check");
	a_supp_gate: assert property (p_supp_gate) else $error("supp under zero check");
	a_x10_gate: assert property (p_x10_gate) else $error("x10 under zero check");
	a_out_gate: assert property (p_out_gate) else $error("output gate wrong");
	a_reset_zc: assert property (p_reset_zc) else $error("zero check off at reset");
	a_nv_hold: assert property (p_nv_hold) else $error("saved constant moved");
	a_srq: assert property (p_srq) else $error("srq without error");
	a_clear_err: assert property (p_clear_err) else $error("error kept over clear");
	a_range: assert property (p_range) else $error("bias level out of range");
endmodule
bind bzc_control bzc_control_props #(.CORR_CYCLES(CORR_CYCLES), .OFFSET_LIMIT(OFFSET_LIMIT))
	bzc_control_props_i (.clk(clk), .reset_n(reset_n), .bias_key_pin(bias_key_pin),
	.dev_clear_pin(dev_clear_pin), .bias_drive(bias_drive), .bias_level(bias_level),
	.supp_enable(supp_enable), .x10_enable(x10_enable), .signal_out_enable(signal_out_enable),
	.zero_check(zero_check), .correction_error_message(correction_error_message),
	.srq(srq), .nv_corr_const(nv_corr_const), .nv_save_strobe(nv_save_strobe));

/* File: bzc_host.sv */
// bus controller model issuing single word AHB-Lite transfers
`timescale 1ns/100ps
module bzc_host (
	input wire clk,
	input wire hready,
	input wire [31:0] hrdata,
	output reg hsel,
	output reg [31:0] haddr,
	output reg [1:0] htrans,
	output reg hwrite,
	output reg [2:0] hsize,
	output reg [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
	end
	////////////////////////////////////////////////////////////////
	task wait_ready;
		integer n;
		begin
			n = 0;
			@(posedge clk);
			while (hready !== 1'b1) begin
				n = n + 1;
				if (n > 16) begin
					testbench.failures++;
					testbench.finish_test;
				end
				@(posedge clk);
			end
		end
	endtask
	// released lines show the inverse so stale data never looks valid
	task xfer(input [7:0] a, input w, input [31:0] d, output [31:0] q);
		begin
			hsel <= 1'b1;
			haddr <= {24'h000000, a};
			htrans <= 2'b10;
			hwrite <= w;
			wait_ready;
			hsel <= 1'b0;
			htrans <= 2'b00;
			haddr <= ~{24'h000000, a};
			hwdata <= w ? d : ~hwdata;
			wait_ready;
			q = hrdata;
			hwdata <= ~hwdata;
		end
	endtask
	task send(input string s);
		reg [31:0] q;
		integer i;
		begin
			for (i = 0; i < s.len(); i++)
				xfer(8'h00, 1'b1, {24'h000000, s[i]}, q);
			repeat (3) @(posedge clk);
			#1;
		end
	endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the bias and zero check control
`timescale 1ns/100ps
`include "bzc_defs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("BAD %0t got %h expected %h", $time, (g), (e)); end end
module testbench;
	localparam CC = 4;
	reg clk = 1'b0;
	reg reset_n = 1'b0;
	reg dev_clear_pin = 1'b0;
	reg bias_key_pin = 1'b0;
	reg [15:0] measured_offset = 16'h0000;
	reg [31:0] q;
	int failures = 0;
	int checked = 0;
	wire hsel, hwrite, hreadyout, hresp, bias_drive, supp_enable, x10_enable;
	wire signal_out_enable, zero_check, correction_error_message, srq, nv_save_strobe;
	wire [31:0] haddr, hwdata, hrdata;
	wire [1:0] htrans;
	wire [2:0] hsize;
	wire [11:0] bias_level;
	wire [15:0] nv_corr_const;
	bzc_host bzc_host_i (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	bzc_control #(.CORR_CYCLES(CC)) bzc_control_i (.clk(clk), .reset_n(reset_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .dev_clear_pin(dev_clear_pin), .bias_key_pin(bias_key_pin),
		.measured_offset(measured_offset), .bias_drive(bias_drive), .bias_level(bias_level),
		.supp_enable(supp_enable), .x10_enable(x10_enable),
		.signal_out_enable(signal_out_enable), .zero_check(zero_check),
		.correction_error_message(correction_error_message), .srq(srq),
		.nv_corr_const(nv_corr_const), .nv_save_strobe(nv_save_strobe));
	initial forever #2.5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task finish_test;
		begin
			$display("checked %0d failures %0d", checked, failures);
			if (failures == 0 && checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task chk_st(input [8:0] e);
		begin
			bzc_host_i.xfer(`BZC_ADDR_STATUS, 1'b0, 32'h0, q);
			`CHK(q[8:0], e)
		end
	endtask
	// polling keeps the bench independent of the correction length
	task wait_idle;
		integer n;
		begin
			n = 0;
			q = 32'h00000040;
			while (q[6] !== 1'b0) begin
				bzc_host_i.xfer(`BZC_ADDR_STATUS, 1'b0, 32'h0, q);
				n = n + 1;
				if (n > 50) begin
					failures++;
					finish_test;
				end
			end
			repeat (2) @(posedge clk);
		end
	endtask
	task pulse_pin(input k);
		begin
			@(posedge clk);
			if (k) bias_key_pin <= 1'b1; else dev_clear_pin <= 1'b1;
			repeat (6) @(posedge clk);
			bias_key_pin <= 1'b0;
			dev_clear_pin <= 1'b0;
			repeat (6) @(posedge clk);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		bzc_host_i.xfer(`BZC_ADDR_CTRL, 1'b0, 32'h0, q);
		`CHK(q, 32'h00000004)
		`CHK(hresp, 1'b0)
		`CHK(hreadyout, 1'b1)
		chk_st(9'h002);
		bzc_host_i.xfer(8'h20, 1'b1, 32'hFFFFFFFF, q);
		bzc_host_i.xfer(8'h20, 1'b0, 32'h0, q);
		`CHK(q, 32'h00000000)
		bzc_host_i.xfer(`BZC_ADDR_CTRL, 1'b1, 32'h0000000B, q);
		bzc_host_i.send("B1X");
		chk_st(9'h003);
		`CHK(bias_drive, 1'b0)
		bzc_host_i.send("C0X");
		chk_st(9'h03D);
		`CHK(signal_out_enable, 1'b1)
		bzc_host_i.send("C1B0X");
		chk_st(9'h002);
		bzc_host_i.send("B1C0X");
		chk_st(9'h03D);
		bzc_host_i.xfer(`BZC_ADDR_VALUE, 1'b1, 32'h00000BB8, q);
		chk_st(9'h13D);
		`CHK(bias_level, 12'h000)
		bzc_host_i.send("X");
		`CHK(bias_level, 12'h7D0)
		bzc_host_i.xfer(`BZC_ADDR_VALUE, 1'b1, 32'hFFFFF63C, q);
		bzc_host_i.send("X");
		`CHK(bias_level, 12'h830)
		bzc_host_i.xfer(`BZC_ADDR_VALUE, 1'b0, 32'h0, q);
		`CHK(q, 32'hFFFFF830)
		measured_offset <= 16'h0100;
		bzc_host_i.send("C2X");
		`CHK(zero_check, 1'b1)
		wait_idle;
		chk_st(9'h03D);
		bzc_host_i.xfer(`BZC_ADDR_NVCONST, 1'b0, 32'h0, q);
		`CHK(q, 32'h00000000)
		bzc_host_i.send("L1X");
		bzc_host_i.xfer(`BZC_ADDR_CONST, 1'b0, 32'h0, q);
		`CHK(q, 32'h00000100)
		`CHK(nv_corr_const, 16'h0100)
		measured_offset <= 16'h2000;
		bzc_host_i.send("C2X");
		wait_idle;
		chk_st(9'h0BD);
		`CHK(srq, 1'b1)
		`CHK(correction_error_message, 1'b1)
		pulse_pin(1'b0);
		chk_st(9'h03D);
		bzc_host_i.xfer(`BZC_ADDR_CTRL, 1'b1, 32'h0000000F, q);
		bzc_host_i.send("L2X");
		chk_st(9'h003);
		bzc_host_i.send("C0X");
		pulse_pin(1'b1);
		chk_st(9'h038);
		bzc_host_i.send("C1X");
		chk_st(9'h002);
		bzc_host_i.xfer(`BZC_ADDR_CTRL, 1'b1, 32'h00000007, q);
		bzc_host_i.xfer(`BZC_ADDR_CTRL, 1'b0, 32'h0, q);
		`CHK(q, 32'h00000007)
		bzc_host_i.send("C2X");
		wait_idle;
		chk_st(9'h082);
		`CHK(srq, 1'b0)
		bzc_host_i.xfer(`BZC_ADDR_STATUS, 1'b1, 32'h00000080, q);
		chk_st(9'h002);
		finish_test;
	end
endmodule
